/* hdl/pcmr_pkg.sv */
package pcmr_pkg;
  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_MASK = 8'h0c;
  localparam logic [7:0] OFS_QUEUE_BASE = 8'h14;
  localparam logic [7:0] OFS_QUEUE_LENGTH = 8'h18;
  localparam logic [7:0] OFS_MODE_ONE = 8'h20;
  localparam logic [7:0] OFS_MODE_TWO = 8'h24;
  // ----------------------------------------
  // reset values and writable bits
  // ----------------------------------------
  localparam logic [31:0] RST_INTERRUPT_MASK = 32'h0000ff7f;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [31:0] WMASK_INTERRUPT_MASK = 32'h0000ffff;
  localparam logic [31:0] WMASK_QUEUE_BASE = 32'hfffffffc;
  localparam logic [31:0] WMASK_QUEUE_LENGTH = 32'h000000ff;
  localparam logic [31:0] WMASK_MODE_ONE = 32'hffffffff;
  localparam logic [31:0] WMASK_MODE_TWO = 32'h000001ff;
  localparam logic [31:0] WMASK_STATUS = 32'h0000ff7f;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int RATE_LSB = 28;
  localparam int TX_SLOT_LSB = 25;
  localparam int TX_SHIFT_LSB = 22;
  localparam int RX_SLOT_LSB = 19;
  localparam int RX_SHIFT_LSB = 16;
  localparam int RX_ENABLE_BIT = 15;
  localparam int RX_IRQ_DISABLE_BIT = 14;
  localparam int FRAME_CHECK_OFF_BIT = 13;
  localparam int HOLD_POLL_BIT = 8;
  localparam int SLOW_POLL_BIT = 7;
  localparam int LATE_STOP_MASK_BIT = 6;
  localparam int RX_SYNC_ERR_MASK_BIT = 5;
  localparam int TX_SYNC_ERR_MASK_BIT = 4;
  localparam int RX_DATA_EDGE_BIT = 3;
  localparam int TX_DATA_EDGE_BIT = 2;
  localparam int RX_SYNC_EDGE_BIT = 1;
  localparam int TX_SYNC_EDGE_BIT = 0;
  // status bits carrying receive and sync error events
  localparam int STAT_RX_EVENT_BIT = 14;
  localparam int STAT_TX_SYNC_BIT = 5;
  localparam int STAT_RX_SYNC_BIT = 4;
  // ----------------------------------------
  // rate codes and constants
  // ----------------------------------------
  localparam logic [3:0] RATE_1536 = 4'h0;
  localparam logic [3:0] RATE_1544 = 4'h4;
  localparam logic [3:0] RATE_3088 = 4'h5;
  localparam logic [3:0] RATE_6176 = 4'h6;
  localparam logic [3:0] RATE_2048 = 4'h8;
  localparam logic [3:0] RATE_4096 = 4'h9;
  localparam logic [3:0] RATE_8192 = 4'ha;
  localparam logic [10:0] QUEUE_MAX_DWORDS = 11'h400;
  localparam logic [2:0] SHIFT_NONE = 3'h4;
  localparam logic [2:0] POLL_FRAMES = 3'h7;
  typedef enum logic [2:0] {
    PCMR_RATE_1536, PCMR_RATE_1544, PCMR_RATE_3088, PCMR_RATE_6176,
    PCMR_RATE_2048, PCMR_RATE_4096, PCMR_RATE_8192, PCMR_RATE_BAD
  } pcmr_rate_e;
endpackage

/* hdl/pcmr_edge_sampler.sv */
`timescale 1ns/100ps
module pcmr_edge_sampler (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // line side
  input wire logic lineClk,
  input wire logic lineData,
  input wire logic lineSync,
  // edge choice
  input wire logic dataOnFall,
  input wire logic syncOnFall,
  // sampled output
  output logic dataBit,
  output logic dataStrobe,
  output logic syncHit
);
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  logic [2:0] clkMeta_q, clkMeta_d;
  logic [1:0] datMeta_q, datMeta_d;
  logic [1:0] synMeta_q, synMeta_d;
  logic dataBit_q, dataBit_d;
  logic dataStrobe_q, dataStrobe_d;
  logic syncHit_q, syncHit_d;
  logic rise;
  logic fall;

  always_comb begin
    clkMeta_d = {clkMeta_q[1:0], lineClk};
    datMeta_d = {datMeta_q[0], lineData};
    synMeta_d = {synMeta_q[0], lineSync};
    rise = clkMeta_q[1] & ~clkMeta_q[2];
    fall = ~clkMeta_q[1] & clkMeta_q[2];
    dataStrobe_d = dataOnFall ? fall : rise;
    dataBit_d = dataStrobe_d ? datMeta_q[1] : dataBit_q;
    syncHit_d = (syncOnFall ? fall : rise) & synMeta_q[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clkMeta_q <= 3'h0;
      datMeta_q <= 2'h0;
      synMeta_q <= 2'h0;
      dataBit_q <= 1'b0;
      dataStrobe_q <= 1'b0;
      syncHit_q <= 1'b0;
    end else begin
      clkMeta_q <= clkMeta_d;
      datMeta_q <= datMeta_d;
      synMeta_q <= synMeta_d;
      dataBit_q <= dataBit_d;
      dataStrobe_q <= dataStrobe_d;
      syncHit_q <= syncHit_d;
    end
  end

  assign dataBit = dataBit_q;
  assign dataStrobe = dataStrobe_q;
  assign syncHit = syncHit_q;
endmodule

/* hdl/pcmr_frame_length.sv */
`timescale 1ns/100ps
module pcmr_frame_length (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic checkOff,
  input wire logic [12:0] maxLength,
  // byte events
  input wire logic byteValid,
  input wire logic frameEnd,
  // result
  output logic frameAbort
);
  logic [13:0] count_q, count_d;
  logic abort_q, abort_d;
  logic over;

  always_comb begin
    over = byteValid && !checkOff && (count_q >= {1'b0, maxLength});
    abort_d = over;
    count_d = count_q;
    if (frameEnd || over) begin
      count_d = 14'h0;
    end else if (byteValid && count_q != 14'h3fff) begin
      count_d = count_q + 14'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_q <= 14'h0;
      abort_q <= 1'b0;
    end else begin
      count_q <= count_d;
      abort_q <= abort_d;
    end
  end

  assign frameAbort = abort_q;
endmodule

/* hdl/pcmr_regs.sv */
`timescale 1ns/100ps
// How it works
// RULE_01: a set mask bit lets the event set its flag but raise no interrupt.
// RULE_02: queue base keeps bits 31 to 2; the two low bits read zero.
// RULE_03: queue length is four times the value; zero means 1024 dwords.
// RULE_04: four-bit rate field picks one of seven line rates.
// RULE_05: software writes only the seven listed rate codes.
// RULE_06: bit-shift code 0 to 7 means shift -4 to +3; code 4 none.
// RULE_07: timeslot code picks slots k*n plus 0 to 3; codes 4-7 reserved.
// RULE_08: in 3 and 4 Mbit modes software uses only the first two offsets.
// RULE_09: receive runs only while receive enable is one.
// RULE_10: receive interrupt disable blocks receive events from the interrupt.
// RULE_11: frame length check off bit disables the maximum length check.
// RULE_12: received frame longer than the maximum is aborted and flagged.
// RULE_13: hold poll with all poll bits zero checks hold every assigned slot.
// RULE_14: slow poll with all poll bits one polls channels n+8i in frame n.
// RULE_15: software avoids slow poll while sub-channeling is used.
// RULE_16: late-stop mask blocks late-stop events from the interrupt.
// RULE_17: sync error masks block sync errors from the interrupt.
// RULE_18: receive data sampled on rising edge, or falling when bit set.
// RULE_19: transmit data uses falling edge, or rising when bit set.
// RULE_20: receive sync sampled on rising edge, or falling when bit set.
// RULE_21: transmit sync sampled on falling edge, or rising when bit set.
// RULE_22: writing one to a status bit clears it and drops the interrupt.
// RULE_23: fixed zero bits read zero and ignore writes.
module pcmr_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic regSel,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  output logic [31:0] regRdata,
  // core events
  input wire logic [15:0] eventIn,
  input wire logic lateStopEvent,
  input wire logic rxByteValid,
  input wire logic rxFrameEnd,
  input wire logic [31:0] txPollBits,
  input wire logic [31:0] txHoldFlag,
  // line pins
  input wire logic rxLineClock,
  input wire logic rxData,
  input wire logic rxSyncPulse,
  input wire logic txLineClock,
  input wire logic txSyncPulse,
  // core side outputs
  output logic hostIrq,
  output logic rxEnable,
  output logic rxBit,
  output logic rxBitStrobe,
  output logic rxFrameStart,
  output logic txBitStrobe,
  output logic txFrameStart,
  output logic rxFrameAbort,
  output logic [10:0] queueDwords,
  output logic [2:0] rateSel,
  output logic [1:0] slotMult,
  output logic [2:0] txSlotOffset,
  output logic [2:0] rxSlotOffset,
  output logic [3:0] txShift,
  output logic [3:0] rxShift,
  output logic [31:0] pollChannels
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] wrMerge(input logic [31:0] old, input logic [31:0] wv,
                                          input logic [31:0] msk);
    wrMerge = (old & ~msk) | (wv & msk);
  endfunction

  function automatic logic [3:0] shiftOf(input logic [2:0] code);
    shiftOf = {1'b0, code} - {1'b0, pcmr_pkg::SHIFT_NONE};
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] intMask_q, intMask_d;
  logic [31:0] queueBase_q, queueBase_d;
  logic [31:0] queueLen_q, queueLen_d;
  logic [31:0] modeOne_q, modeOne_d;
  logic [31:0] modeTwo_q, modeTwo_d;
  logic [31:0] status_q, status_d;
  logic [31:0] rdata_q, rdata_d;
  logic [2:0] pollFrame_q, pollFrame_d;
  logic [31:0] events;
  logic [31:0] irqGate;
  logic wr;
  logic rxSyncHit;
  logic txSyncHit;
  logic abortRaw;

  assign wr = regSel && regWrite;

  always_comb begin
    intMask_d = intMask_q;
    queueBase_d = queueBase_q;
    queueLen_d = queueLen_q;
    modeOne_d = modeOne_q;
    modeTwo_d = modeTwo_q;
    if (wr) begin
      if (regAddr == pcmr_pkg::OFS_INTERRUPT_MASK) begin
        intMask_d = wrMerge(intMask_q, regWdata, pcmr_pkg::WMASK_INTERRUPT_MASK);
      end else if (regAddr == pcmr_pkg::OFS_QUEUE_BASE) begin
        queueBase_d = wrMerge(queueBase_q, regWdata, pcmr_pkg::WMASK_QUEUE_BASE); // RULE_02
      end else if (regAddr == pcmr_pkg::OFS_QUEUE_LENGTH) begin
        queueLen_d = wrMerge(queueLen_q, regWdata, pcmr_pkg::WMASK_QUEUE_LENGTH); // RULE_23
      end else if (regAddr == pcmr_pkg::OFS_MODE_ONE) begin
        modeOne_d = wrMerge(modeOne_q, regWdata, pcmr_pkg::WMASK_MODE_ONE);
      end else if (regAddr == pcmr_pkg::OFS_MODE_TWO) begin
        modeTwo_d = wrMerge(modeTwo_q, regWdata, pcmr_pkg::WMASK_MODE_TWO); // RULE_23
      end
    end
  end

  // ----------------------------------------
  // status flags and interrupt
  // ----------------------------------------
  always_comb begin
    events = {16'h0, eventIn};
    events[pcmr_pkg::STAT_RX_EVENT_BIT] = eventIn[pcmr_pkg::STAT_RX_EVENT_BIT] | abortRaw; // RULE_12
    events[pcmr_pkg::STAT_RX_EVENT_BIT - 1] = eventIn[pcmr_pkg::STAT_RX_EVENT_BIT - 1]
                                              | lateStopEvent;
    events = events & pcmr_pkg::WMASK_STATUS;
    status_d = status_q;
    if (wr && regAddr == pcmr_pkg::OFS_STATUS) begin
      status_d = status_q & ~(regWdata & pcmr_pkg::WMASK_STATUS); // RULE_22
    end
    status_d = status_d | events;
    irqGate = ~intMask_q; // RULE_01
    if (modeOne_q[pcmr_pkg::RX_IRQ_DISABLE_BIT]) begin
      irqGate[pcmr_pkg::STAT_RX_EVENT_BIT] = 1'b0; // RULE_10
    end
    if (modeTwo_q[pcmr_pkg::LATE_STOP_MASK_BIT]) begin
      irqGate[pcmr_pkg::STAT_RX_EVENT_BIT - 1] = 1'b0; // RULE_16
    end
    if (modeTwo_q[pcmr_pkg::RX_SYNC_ERR_MASK_BIT]) begin
      irqGate[pcmr_pkg::STAT_RX_SYNC_BIT] = 1'b0; // RULE_17
    end
    if (modeTwo_q[pcmr_pkg::TX_SYNC_ERR_MASK_BIT]) begin
      irqGate[pcmr_pkg::STAT_TX_SYNC_BIT] = 1'b0; // RULE_17
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    if (regAddr == pcmr_pkg::OFS_STATUS) begin
      rdata_d = status_q;
    end else if (regAddr == pcmr_pkg::OFS_INTERRUPT_MASK) begin
      rdata_d = intMask_q;
    end else if (regAddr == pcmr_pkg::OFS_QUEUE_BASE) begin
      rdata_d = queueBase_q;
    end else if (regAddr == pcmr_pkg::OFS_QUEUE_LENGTH) begin
      rdata_d = queueLen_q;
    end else if (regAddr == pcmr_pkg::OFS_MODE_ONE) begin
      rdata_d = modeOne_q;
    end else if (regAddr == pcmr_pkg::OFS_MODE_TWO) begin
      rdata_d = modeTwo_q;
    end
  end

  // ----------------------------------------
  // slow poll frame counter
  // ----------------------------------------
  always_comb begin
    pollFrame_d = pollFrame_q;
    if (txSyncHit) begin
      pollFrame_d = (pollFrame_q == pcmr_pkg::POLL_FRAMES) ? 3'h0 : pollFrame_q + 3'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      intMask_q <= pcmr_pkg::RST_INTERRUPT_MASK;
      queueBase_q <= pcmr_pkg::RST_ZERO;
      queueLen_q <= pcmr_pkg::RST_ZERO;
      modeOne_q <= pcmr_pkg::RST_ZERO;
      modeTwo_q <= pcmr_pkg::RST_ZERO;
      status_q <= pcmr_pkg::RST_ZERO;
      rdata_q <= 32'h0;
      pollFrame_q <= 3'h0;
    end else begin
      intMask_q <= intMask_d;
      queueBase_q <= queueBase_d;
      queueLen_q <= queueLen_d;
      modeOne_q <= modeOne_d;
      modeTwo_q <= modeTwo_d;
      status_q <= status_d;
      rdata_q <= rdata_d;
      pollFrame_q <= pollFrame_d;
    end
  end

  assign regRdata = rdata_q;
  assign hostIrq = |(status_q & irqGate);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  always_comb begin
    queueDwords = (queueLen_q[7:0] == 8'h0) ? pcmr_pkg::QUEUE_MAX_DWORDS
                  : {1'b0, queueLen_q[7:0], 2'b00}; // RULE_03
    case (modeOne_q[pcmr_pkg::RATE_LSB +: 4]) // RULE_04
      pcmr_pkg::RATE_1536: rateSel = pcmr_pkg::PCMR_RATE_1536;
      pcmr_pkg::RATE_1544: rateSel = pcmr_pkg::PCMR_RATE_1544;
      pcmr_pkg::RATE_3088: rateSel = pcmr_pkg::PCMR_RATE_3088;
      pcmr_pkg::RATE_6176: rateSel = pcmr_pkg::PCMR_RATE_6176;
      pcmr_pkg::RATE_2048: rateSel = pcmr_pkg::PCMR_RATE_2048;
      pcmr_pkg::RATE_4096: rateSel = pcmr_pkg::PCMR_RATE_4096;
      pcmr_pkg::RATE_8192: rateSel = pcmr_pkg::PCMR_RATE_8192;
      default: rateSel = pcmr_pkg::PCMR_RATE_BAD;
    endcase
    case (rateSel) // RULE_07
      pcmr_pkg::PCMR_RATE_3088, pcmr_pkg::PCMR_RATE_4096: slotMult = 2'h1;
      pcmr_pkg::PCMR_RATE_6176, pcmr_pkg::PCMR_RATE_8192: slotMult = 2'h2;
      default: slotMult = 2'h0;
    endcase
    txSlotOffset = modeOne_q[pcmr_pkg::TX_SLOT_LSB +: 3];
    rxSlotOffset = modeOne_q[pcmr_pkg::RX_SLOT_LSB +: 3];
    txShift = shiftOf(modeOne_q[pcmr_pkg::TX_SHIFT_LSB +: 3]); // RULE_06
    rxShift = shiftOf(modeOne_q[pcmr_pkg::RX_SHIFT_LSB +: 3]); // RULE_06
    pollChannels = 32'h0;
    if (modeTwo_q[pcmr_pkg::HOLD_POLL_BIT] && txPollBits == 32'h0) begin
      pollChannels = txHoldFlag; // RULE_13
    end else if (modeTwo_q[pcmr_pkg::SLOW_POLL_BIT] && txPollBits == 32'hffffffff) begin
      pollChannels = 32'h01010101 << pollFrame_q; // RULE_14
    end
  end

  assign rxEnable = modeOne_q[pcmr_pkg::RX_ENABLE_BIT]; // RULE_09
  assign rxFrameStart = rxSyncHit & rxEnable;

  // ----------------------------------------
  // line samplers
  // ----------------------------------------
  pcmr_edge_sampler rxSampler (
    .clk(clk),
    .rst_n(rst_n),
    .lineClk(rxLineClock),
    .lineData(rxData),
    .lineSync(rxSyncPulse),
    .dataOnFall(modeTwo_q[pcmr_pkg::RX_DATA_EDGE_BIT]), // RULE_18
    .syncOnFall(modeTwo_q[pcmr_pkg::RX_SYNC_EDGE_BIT]), // RULE_20
    .dataBit(rxBit),
    .dataStrobe(rxBitStrobe),
    .syncHit(rxSyncHit)
  );

  pcmr_edge_sampler txSampler (
    .clk(clk),
    .rst_n(rst_n),
    .lineClk(txLineClock),
    .lineData(1'b0),
    .lineSync(txSyncPulse),
    .dataOnFall(~modeTwo_q[pcmr_pkg::TX_DATA_EDGE_BIT]), // RULE_19
    .syncOnFall(~modeTwo_q[pcmr_pkg::TX_SYNC_EDGE_BIT]), // RULE_21
    .dataBit(),
    .dataStrobe(txBitStrobe),
    .syncHit(txSyncHit)
  );

  assign txFrameStart = txSyncHit;

  pcmr_frame_length frameCheck (
    .clk(clk),
    .rst_n(rst_n),
    .checkOff(modeOne_q[pcmr_pkg::FRAME_CHECK_OFF_BIT]), // RULE_11
    .maxLength(modeOne_q[12:0]),
    .byteValid(rxByteValid & rxEnable),
    .frameEnd(rxFrameEnd),
    .frameAbort(abortRaw)
  );

  assign rxFrameAbort = abortRaw;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_MASK_RESET: assert property (@(posedge clk) $rose(rst_n) |->
    intMask_q == 32'h0000ff7f) else $error("mask reset wrong"); // RULE_01
  AST_BASE_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    queueBase_q[1:0] == 2'b00) else $error("base low bits set"); // RULE_02
  AST_QLEN: assert property (@(posedge clk) disable iff (!rst_n)
    queueLen_q[7:0] == 8'h0 |-> queueDwords == 11'h400) else $error("qlen"); // RULE_03
  AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    wr && regAddr == 8'h08 && regWdata[0] && !events[0] |=> !status_q[0])
    else $error("status not cleared"); // RULE_22
  AST_SET_WINS: assert property (@(posedge clk) disable iff (!rst_n)
    events[0] |=> status_q[0]) else $error("event lost"); // RULE_01
  AST_RID: assert property (@(posedge clk) disable iff (!rst_n)
    modeOne_q[14] && status_q == 32'h00004000 |-> !hostIrq) else $error("rid"); // RULE_10
  AST_RX_EN: assert property (@(posedge clk) disable iff (!rst_n)
    !rxEnable |-> !rxFrameStart) else $error("rx while disabled"); // RULE_09
  AST_CORE_MODE_TWO_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
    modeTwo_q[31:9] == 23'h0) else $error("mode two fixed bits"); // RULE_23
  AST_SLOW: assert property (@(posedge clk) disable iff (!rst_n)
    modeTwo_q[7] && !modeTwo_q[8] && txPollBits == 32'hffffffff |->
    $countones(pollChannels) == 4) else $error("slow poll"); // RULE_14
endmodule

/* verification/pcmr_line_model.sv */
`timescale 1ns/100ps
module pcmr_line_model (
  // control from bench
  input wire logic run,
  input wire logic dataRise,
  input wire logic dataFall,
  // line pins
  output logic rxLineClock,
  output logic rxData,
  output logic rxSyncPulse,
  output logic txLineClock,
  output logic txSyncPulse,
  // last transmit edge, 1 rising, valid 100 ns after it
  output logic txKind
);
  // ----------------------------------------
  // line generator, 400 ns bits, 8-bit frames
  // ----------------------------------------
  int bitNo;
  initial begin
    rxLineClock = 1'b0;
    txLineClock = 1'b0;
    rxData = 1'b0;
    rxSyncPulse = 1'b0;
    txSyncPulse = 1'b0;
    txKind = 1'b0;
    bitNo = 0;
    #37;
    forever begin
      #100;
      txKind = 1'b0;
      if (run) begin
        // rx sync spans only the rising edge
        rxData = dataRise;
        rxSyncPulse = (bitNo == 0);
        txSyncPulse = 1'b0;
        #100;
        rxLineClock = 1'b1;
        txLineClock = 1'b1;
        #100;
        // tx sync spans only the falling edge
        txKind = 1'b1;
        rxData = dataFall;
        rxSyncPulse = 1'b0;
        txSyncPulse = (bitNo == 0);
        #100;
        rxLineClock = 1'b0;
        txLineClock = 1'b0;
        bitNo = (bitNo + 1) % 8;
      end else begin
        // clocks stand still, data keeps moving
        rxData = ~rxData;
        rxSyncPulse = 1'b0;
        txSyncPulse = 1'b0;
      end
    end
  end
endmodule

/* verification/pcm_core_mode_and_irq_mask_regs_test.sv */
`timescale 1ns/100ps
`define CHK(got, exp) \
  begin \
    nChecks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

module pcm_core_mode_and_irq_mask_regs_test;
  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic clk, rst_n, regSel, regWrite;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [15:0] eventIn;
  logic lateStopEvent, rxByteValid, rxFrameEnd;
  logic [31:0] txPollBits, txHoldFlag, pollChannels;
  logic rxLineClock, rxData, rxSyncPulse, txLineClock, txSyncPulse;
  logic hostIrq, rxEnable, rxBit, rxBitStrobe, rxFrameStart, txBitStrobe, txFrameStart;
  logic rxFrameAbort;
  logic [10:0] queueDwords;
  logic [2:0] rateSel, txSlotOffset, rxSlotOffset;
  logic [1:0] slotMult;
  logic [3:0] txShift, rxShift;
  logic run, dataRise, dataFall, txKind;
  int mismatches, nChecks, rxStrobes, rxOnes, txStrobes, txRises, rxFrames, txFrames, aborts;
  logic [31:0] polls[$];
  logic [7:0] offs[5] = '{8'h0c, 8'h14, 8'h18, 8'h20, 8'h24};
  logic [31:0] rsts[5] = '{32'h0000ff7f, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] pats[5] = '{32'hffffffff, 32'hffffffff, 32'hffffffff, 32'ha6d9ffff, 32'hffffffff};
  logic [31:0] wmsk[5] = '{pcmr_pkg::WMASK_INTERRUPT_MASK, pcmr_pkg::WMASK_QUEUE_BASE,
    pcmr_pkg::WMASK_QUEUE_LENGTH, pcmr_pkg::WMASK_MODE_ONE, pcmr_pkg::WMASK_MODE_TWO};

  pcmr_regs dut (
    .clk, .rst_n, .regSel, .regWrite, .regAddr, .regWdata, .regRdata, .eventIn,
    .lateStopEvent, .rxByteValid, .rxFrameEnd, .txPollBits, .txHoldFlag,
    .rxLineClock, .rxData, .rxSyncPulse, .txLineClock, .txSyncPulse,
    .hostIrq, .rxEnable, .rxBit, .rxBitStrobe, .rxFrameStart, .txBitStrobe,
    .txFrameStart, .rxFrameAbort, .queueDwords, .rateSel, .slotMult,
    .txSlotOffset, .rxSlotOffset, .txShift, .rxShift, .pollChannels
  );
  pcmr_line_model line (
    .run, .dataRise, .dataFall, .rxLineClock, .rxData, .rxSyncPulse,
    .txLineClock, .txSyncPulse, .txKind
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(negedge clk) begin
    if (rxBitStrobe === 1'b1) begin
      rxStrobes++;
      rxOnes += int'(rxBit === 1'b1);
    end
    if (txBitStrobe === 1'b1) begin
      txStrobes++;
      txRises += int'(txKind === 1'b1);
    end
    if (txFrameStart === 1'b1) begin
      txFrames++;
      polls.push_back(pollChannels);
    end
    rxFrames += int'(rxFrameStart === 1'b1);
    aborts += int'(rxFrameAbort === 1'b1);
  end

  // ----------------------------------------
  // register access and closing
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regSel = 1'b1;
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regSel = 1'b0;
    regWrite = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    regSel = 1'b1;
    regAddr = a;
    @(negedge clk);
    d = regRdata;
    regSel = 1'b0;
    @(negedge clk);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic check_access;
    logic [31:0] d;
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], d);
      `CHK(d, rsts[i])
      wr(offs[i], pats[i]);
      rd(offs[i], d);
      `CHK(d, pats[i] & wmsk[i])
    end
    rd(8'h14, d);
    `CHK(d[1:0], 2'b00)
    wr(8'h1c, 32'hffffffff);
    rd(8'h1c, d);
    `CHK(d, 32'h0)
  endtask

  task automatic check_queue;
    logic [7:0] v[4] = '{8'h00, 8'h01, 8'h80, 8'hff};
    logic [10:0] x[4] = '{11'h400, 11'h004, 11'h200, 11'h3fc};
    for (int i = 0; i < 4; i++) begin
      wr(8'h18, {24'h0, v[i]});
      repeat (2) @(negedge clk);
      `CHK(queueDwords, x[i])
    end
  endtask

  task automatic check_fields;
    logic [3:0] codes[7] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha};
    logic [1:0] mults[7] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h0, 2'h1, 2'h2};
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      // listed rate codes only, first two slot options only
      wr(8'h20, {codes[i % 7], 2'b00, c[0], c, 2'b00, ~c[0], ~c, c[0], 15'h0});
      repeat (2) @(negedge clk);
      `CHK(rateSel, 3'(i % 7))
      `CHK(slotMult, mults[i % 7])
      `CHK(txSlotOffset, {2'b00, c[0]})
      `CHK(rxSlotOffset, {2'b00, ~c[0]})
      `CHK(txShift, {1'b0, c} - 4'h4)
      `CHK(rxShift, {1'b0, ~c} - 4'h4)
      `CHK(rxEnable, c[0])
    end
  endtask

  task automatic irq_case(input logic [31:0] m, input logic [31:0] m1, input logic [31:0] m2,
                          input int b, input logic expIrq);
    logic [31:0] d;
    wr(8'h0c, m);
    wr(8'h20, m1);
    wr(8'h24, m2);
    if (b == 13) lateStopEvent = 1'b1;
    else eventIn[b] = 1'b1;
    @(negedge clk);
    lateStopEvent = 1'b0;
    eventIn = 16'h0;
    repeat (2) @(negedge clk);
    `CHK(hostIrq, expIrq)
    rd(8'h08, d);
    `CHK(d, (b == 7) ? 32'h0 : (32'h1 << b))
    wr(8'h08, 32'h1 << b);
    repeat (2) @(negedge clk);
    `CHK(hostIrq, 1'b0)
    rd(8'h08, d);
    `CHK(d, 32'h0)
  endtask

  task automatic check_length;
    logic [31:0] d;
    int base;
    base = aborts;
    wr(8'h20, 32'h00008003);
    for (int i = 0; i < 4; i++) begin
      rxByteValid = 1'b1;
      @(negedge clk);
      rxByteValid = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(aborts - base, int'(i == 3))
    end
    rd(8'h08, d);
    `CHK(d[14], 1'b1)
    rxFrameEnd = 1'b1;
    @(negedge clk);
    rxFrameEnd = 1'b0;
    wr(8'h20, 32'h0000a003);
    repeat (5) begin
      rxByteValid = 1'b1;
      @(negedge clk);
      rxByteValid = 1'b0;
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    `CHK(aborts - base, 1)
    // receive off: bytes must not reach the length check
    wr(8'h20, 32'h00000003);
    repeat (5) begin
      rxByteValid = 1'b1;
      @(negedge clk);
      rxByteValid = 1'b0;
      @(negedge clk);
    end
    repeat (3) @(negedge clk);
    `CHK(aborts - base, 1)
  endtask

  task automatic check_line;
    logic [3:0] sel[4] = '{4'h0, 4'hf, 4'ha, 4'h5};
    for (int i = 0; i < 4; i++) begin
      wr(8'h20, 32'h00008000);
      wr(8'h24, {28'h0, sel[i]});
      rxStrobes = 0;
      rxOnes = 0;
      txStrobes = 0;
      txRises = 0;
      rxFrames = 0;
      txFrames = 0;
      run = 1'b1;
      repeat (300) @(negedge clk);
      run = 1'b0;
      repeat (20) @(negedge clk);
      `CHK(rxStrobes > 8 && txStrobes > 8, 1'b1)
      `CHK(rxOnes == (sel[i][3] ? 0 : rxStrobes), 1'b1)
      `CHK(txRises == (sel[i][2] ? txStrobes : 0), 1'b1)
      `CHK(rxFrames > 0, ~sel[i][1])
      `CHK(txFrames > 0, ~sel[i][0])
    end
  endtask

  task automatic check_poll;
    logic [31:0] e;
    // no sub-channeling in use while slow poll runs
    wr(8'h24, 32'h00000080);
    txPollBits = 32'hffffffff;
    polls.delete();
    run = 1'b1;
    repeat (700) @(negedge clk);
    run = 1'b0;
    `CHK(polls.size() > 8, 1'b1)
    `CHK($countones(polls[0]) == 4 && polls[0][7:0] * 32'h01010101 == polls[0], 1'b1)
    for (int i = 1; i < polls.size(); i++) begin
      e = (polls[i-1] == 32'h80808080) ? 32'h01010101 : (polls[i-1] << 1);
      `CHK(polls[i], e)
    end
    wr(8'h24, 32'h00000100);
    txPollBits = 32'h0;
    txHoldFlag = 32'h00a5005a;
    @(negedge clk);
    `CHK(pollChannels, 32'h00a5005a)
    txPollBits = 32'h00000001;
    @(negedge clk);
    `CHK(pollChannels, 32'h0)
  endtask

  initial begin
    rst_n = 1'b0;
    regSel = 1'b0;
    regWrite = 1'b0;
    regAddr = 8'h0;
    regWdata = 32'h0;
    eventIn = 16'h0;
    lateStopEvent = 1'b0;
    rxByteValid = 1'b0;
    rxFrameEnd = 1'b0;
    txPollBits = 32'h0;
    txHoldFlag = 32'h0;
    run = 1'b0;
    dataRise = 1'b1;
    dataFall = 1'b0;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    check_access();
    check_queue();
    check_fields();
    irq_case(32'h0, 32'h0, 32'h0, 0, 1'b1);
    irq_case(32'h1, 32'h0, 32'h0, 0, 1'b0);
    irq_case(32'h0, 32'h4000, 32'h0, 14, 1'b0);
    irq_case(32'h0, 32'h0, 32'h0, 14, 1'b1);
    irq_case(32'h0, 32'h0, 32'h40, 13, 1'b0);
    irq_case(32'h0, 32'h0, 32'h0, 13, 1'b1);
    irq_case(32'h0, 32'h0, 32'h20, 4, 1'b0);
    irq_case(32'h0, 32'h0, 32'h10, 5, 1'b0);
    irq_case(32'h0, 32'h0, 32'h0, 5, 1'b1);
    irq_case(32'h0, 32'h0, 32'h0, 7, 1'b0);
    check_length();
    check_line();
    check_poll();
    wrap_up();
  end
endmodule
